// ---- logic/msct_ctrl.sv ----
// Local design decisions: the APB slave port and the address map.
`include "msct_map.svh"
`default_nettype none
module msct_ctrl (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic MEM_CLK,
    output logic [1:0] MEM_CS_N,
    output logic MEM_ADV_N,
    output logic MEM_OE_N,
    output logic MEM_WE_N,
    output logic [15:0] MEM_AD_O,
    output logic MEM_AD_OE,
    input wire logic [15:0] MEM_AD_I
);
    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    // Strobe length, never below one cycle
    function automatic logic [8:0] msct_len(
        input logic [3:0] w,
        input logic [7:0] d,
        input logic use_d
    );
        logic [8:0] s;
        s = {5'h00, w} + (use_d ? {1'b0, d} : 9'h000);
        msct_len = (s == 9'h000) ? 9'h001 : s;
    endfunction : msct_len

    msct_pkg::msct_state_t st_q, st_d;
    logic [8:0] cnt_q, cnt_d;
    logic [31:0] fast_q, slow_q, prdata_q;
    logic [15:0] addr_q, wdata_q, rdata_q, ad_q;
    logic [2:0] mode_q;
    logic dir_q, cs_q, id_q, cont_q, ext_q;
    logic last_read_q, last_cs_q;
    logic [15:0] s1_q, s2_q, s3_q, filt_q;

    // ---------------------------------------------
    // Register bus
    // ---------------------------------------------
    wire apb_wr = PSEL & PENABLE & PWRITE;
    wire apb_setup = PSEL & ~PENABLE;
    wire hit_fast = (PADDR == `MSCT_OFS_FAST);
    wire hit_slow = (PADDR == `MSCT_OFS_SLOW);
    wire hit_addr = (PADDR == `MSCT_OFS_ADDR);
    wire hit_data = (PADDR == `MSCT_OFS_DATA);
    wire hit_cmd = (PADDR == `MSCT_OFS_CMD);
    wire hit_mode = (PADDR == `MSCT_OFS_MODE);
    wire hit_stat = (PADDR == `MSCT_OFS_STAT);
    wire mapped = hit_fast | hit_slow | hit_addr | hit_data | hit_cmd
        | hit_mode | hit_stat;
    wire busy = (st_q != msct_pkg::ST_IDLE);
    wire [31:0] stat_w = {30'h0000_0000, last_read_q, busy};
    wire [31:0] rd_mux = hit_fast ? fast_q :
        hit_slow ? slow_q :
        hit_addr ? {16'h0000, addr_q} :
        hit_data ? {16'h0000, rdata_q} :
        hit_mode ? {29'h0000_0000, mode_q} :
        hit_stat ? stat_w : 32'h0000_0000;

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    assign PRDATA = prdata_q;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prdata_q <= 32'h0000_0000;
        end else if (apb_setup & ~PWRITE) begin
            prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            fast_q <= `MSCT_FAST_RST;
            slow_q <= `MSCT_SLOW_RST;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            mode_q <= 3'h0;
        end else if (apb_wr) begin
            if (hit_fast) fast_q <= PWDATA;
            if (hit_slow) slow_q <= PWDATA;
            if (hit_addr) addr_q <= PWDATA[15:0];
            if (hit_data) wdata_q <= PWDATA[15:0];
            if (hit_mode) mode_q <= PWDATA[2:0];
        end
    end
    // Suggested values live in the map as FAST_REC and SLOW_REC

    // ---------------------------------------------
    // Timing fields
    // ---------------------------------------------
    wire ah = fast_q[`MSCT_AH_BIT];
    wire [1:0] aor = fast_q[`MSCT_AOR_LSB +: 2];
    wire [3:0] rd_hold = fast_q[`MSCT_RDH_LSB +: 4];
    wire [3:0] rd_wait = slow_q[`MSCT_RDW_LSB +: 4];
    wire [3:0] wr_wait = slow_q[`MSCT_WRW_LSB +: 4];
    wire [7:0] rd_delta = slow_q[`MSCT_RDD_LSB +: 8];
    wire [7:0] wr_delta = slow_q[`MSCT_WRD_LSB +: 8];
    wire [3:0] wr_hold = slow_q[`MSCT_WRH_LSB +: 4];
    wire [3:0] rec = slow_q[`MSCT_REC_LSB +: 4];

    // Delta skipped on later burst accesses
    wire wr_use_d = ~(mode_q[`MSCT_MODE_WB] & cont_q);
    // Delta skipped on later page or burst accesses
    wire rd_use_d = ~((mode_q[`MSCT_MODE_RP] | mode_q[`MSCT_MODE_RB])
        & cont_q);
    wire [8:0] wr_len = msct_len(wr_wait, wr_delta, wr_use_d);
    wire [8:0] rd_len = msct_len(rd_wait, rd_delta, rd_use_d);

    // Read hold counts from select low; id reads ignore it
    wire [3:0] rdh_gap = (id_q | rd_hold == 4'h0) ? 4'h0 :
        rd_hold - 4'h1;
    wire [3:0] gap0 = ({2'b00, aor} > rdh_gap) ? {2'b00, aor} : rdh_gap;
    // Gap never shorter than the address extension
    wire [3:0] gap_n = ({3'b000, ah} > gap0) ? {3'b000, ah} : gap0;

    // ---------------------------------------------
    // Command start and recovery decision
    // ---------------------------------------------
    wire start = apb_wr & hit_cmd & ~busy;
    wire cmd_wr = PWDATA[`MSCT_CMD_WR];
    wire cmd_cs = PWDATA[`MSCT_CMD_CS];
    wire cmd_cont = PWDATA[`MSCT_CMD_CONT];
    // Only after a read, on turnover or read-write
    wire need_rec = last_read_q & (rec != 4'h0) & ~cmd_cont
        & ((cmd_cs != last_cs_q) | cmd_wr);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            dir_q <= 1'b0;
            cs_q <= 1'b0;
            id_q <= 1'b0;
            cont_q <= 1'b0;
            last_read_q <= 1'b0;
            last_cs_q <= 1'b0;
        end else if (start) begin
            dir_q <= cmd_wr;
            cs_q <= cmd_cs;
            id_q <= PWDATA[`MSCT_CMD_ID];
            cont_q <= cmd_cont;
            last_read_q <= ~cmd_wr;
            last_cs_q <= cmd_cs;
        end
    end

    // ---------------------------------------------
    // Access sequencer
    // ---------------------------------------------
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q - 9'h001;
        case (st_q)
            msct_pkg::ST_IDLE: begin
                cnt_d = 9'h000;
                if (start & need_rec) begin
                    st_d = msct_pkg::ST_RECOV;
                    cnt_d = {5'h00, rec} - 9'h001;
                end else if (start) begin
                    st_d = msct_pkg::ST_ADDR;
                end
            end
            msct_pkg::ST_RECOV: begin
                if (cnt_q == 9'h000) st_d = msct_pkg::ST_ADDR;
            end
            msct_pkg::ST_ADDR: begin
                // Write strobe follows the latch cycle
                if (dir_q) begin
                    st_d = msct_pkg::ST_STROBE;
                    cnt_d = wr_len - 9'h001;
                end else if (gap_n != 4'h0) begin
                    st_d = msct_pkg::ST_GAP;
                    cnt_d = {5'h00, gap_n} - 9'h001;
                end else begin
                    st_d = msct_pkg::ST_STROBE;
                    cnt_d = rd_len - 9'h001;
                end
            end
            msct_pkg::ST_GAP: begin
                if (cnt_q == 9'h000) begin
                    st_d = msct_pkg::ST_STROBE;
                    cnt_d = rd_len - 9'h001;
                end
            end
            msct_pkg::ST_STROBE: begin
                if (cnt_q == 9'h000) begin
                    // Write hold after the write strobe
                    if (dir_q & (wr_hold != 4'h0)) begin
                        st_d = msct_pkg::ST_HOLD;
                        cnt_d = {5'h00, wr_hold} - 9'h001;
                    end else begin
                        st_d = msct_pkg::ST_IDLE;
                    end
                end
            end
            msct_pkg::ST_HOLD: begin
                if (cnt_q == 9'h000) st_d = msct_pkg::ST_IDLE;
            end
            default: begin
                st_d = msct_pkg::ST_IDLE;
                cnt_d = 9'h000;
            end
        endcase
    end

    // Extension cycle right after the latch cycle
    wire ext_d = (st_q == msct_pkg::ST_ADDR) & ah;
    wire addr_phase = (st_d == msct_pkg::ST_ADDR) | ext_d;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st_q <= msct_pkg::ST_IDLE;
            cnt_q <= 9'h000;
            ext_q <= 1'b0;
            ad_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ext_q <= ext_d;
            ad_q <= addr_phase ? addr_q : wdata_q;
        end
    end

    // ---------------------------------------------
    // Memory pins
    // ---------------------------------------------
    wire in_strobe = (st_q == msct_pkg::ST_STROBE);
    wire cs_act = (st_q == msct_pkg::ST_ADDR)
        | (st_q == msct_pkg::ST_GAP) | in_strobe
        | (st_q == msct_pkg::ST_HOLD);
    wire wr_drive = dir_q & (in_strobe | (st_q == msct_pkg::ST_HOLD));

    // No memory clock in asynchronous mode
    assign MEM_CLK = 1'b0;
    assign MEM_CS_N = ~cs_act ? 2'b11 : (cs_q ? 2'b01 : 2'b10);
    // Address valid strobe only during the latch cycle
    assign MEM_ADV_N = ~(st_q == msct_pkg::ST_ADDR);
    assign MEM_OE_N = ~(in_strobe & ~dir_q);
    assign MEM_WE_N = ~(in_strobe & dir_q);
    assign MEM_AD_O = ad_q;
    // Never drive the shared lines under the read strobe
    assign MEM_AD_OE = ((st_q == msct_pkg::ST_ADDR) | ext_q | wr_drive)
        & MEM_OE_N;

    // ---------------------------------------------
    // Read data capture
    // ---------------------------------------------
    // Three-stage sync; data seen lags the pins by at least four cycles,
    // so the read strobe must cover that lag in addition to access time
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            s1_q <= 16'h0000;
            s2_q <= 16'h0000;
            s3_q <= 16'h0000;
            filt_q <= 16'h0000;
            rdata_q <= 16'h0000;
        end else begin
            s1_q <= MEM_AD_I;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) filt_q <= s3_q;
            if (in_strobe & ~dir_q & (cnt_q == 9'h000)) rdata_q <= filt_q;
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking msct_cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    mem_clk_low_a: assert property (MEM_CLK == 1'b0)
        else $error("memory clock not low");
    ad_release_a: assert property (!MEM_OE_N |-> !(ext_q | wr_drive))
        else $error("bus driven under read strobe");
    addr_extend_a: assert property (
        (!MEM_ADV_N && ah) |=> (MEM_ADV_N && MEM_AD_OE
        && MEM_AD_O == $past(addr_q)))
        else $error("address not extended");
    read_gap_a: assert property (
        (!MEM_ADV_N && !dir_q && aor == 2'h2 && rdh_gap <= 4'h2)
        |=> MEM_OE_N [*2] ##1 !MEM_OE_N)
        else $error("latch to read gap wrong");
    write_delay_a: assert property (
        ($fell(&MEM_CS_N) && dir_q) |-> MEM_WE_N ##1 !MEM_WE_N)
        else $error("write strobe not one cycle after select");
    write_hold_a: assert property (
        ($rose(MEM_WE_N) && wr_hold == 4'h1) |-> !(&MEM_CS_N)
        ##1 (&MEM_CS_N))
        else $error("write hold length wrong");
    write_len_a: assert property (
        ($fell(MEM_WE_N) && wr_len == 9'h002)
        |-> !MEM_WE_N [*2] ##1 MEM_WE_N)
        else $error("write strobe length wrong");
    recov_idle_a: assert property (
        (st_q == msct_pkg::ST_RECOV) |-> (&MEM_CS_N && MEM_OE_N
        && MEM_WE_N && !MEM_AD_OE))
        else $error("bus active in recovery");
    no_recov_a: assert property (
        (start && !need_rec) |=> !MEM_ADV_N)
        else $error("recovery inserted when not needed");
    reset_vals_a: assert property (
        $rose(RST_N) |-> (slow_q == `MSCT_SLOW_RST
        && fast_q == `MSCT_FAST_RST))
        else $error("reset values wrong");

    wr_access_c: cover property ($fell(MEM_WE_N) ##[1:40] $rose(MEM_WE_N));
    rd_recov_c: cover property (st_q == msct_pkg::ST_RECOV ##1
        st_q == msct_pkg::ST_ADDR);
    id_read_c: cover property (!MEM_OE_N && id_q);
endmodule : msct_ctrl
`default_nettype wire

// ---- logic/msct_map.svh ----
`ifndef MSCT_MAP_SVH
`define MSCT_MAP_SVH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define MSCT_OFS_FAST 12'h000
`define MSCT_OFS_SLOW 12'h004
`define MSCT_OFS_ADDR 12'h008
`define MSCT_OFS_DATA 12'h00C
`define MSCT_OFS_CMD 12'h010
`define MSCT_OFS_MODE 12'h014
`define MSCT_OFS_STAT 12'h018
// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define MSCT_AH_BIT 5
`define MSCT_AOR_LSB 16
`define MSCT_RDH_LSB 24
`define MSCT_RDW_LSB 0
`define MSCT_WRW_LSB 4
`define MSCT_RDD_LSB 8
`define MSCT_WRD_LSB 16
`define MSCT_WRH_LSB 24
`define MSCT_REC_LSB 28
`define MSCT_CMD_WR 0
`define MSCT_CMD_CS 1
`define MSCT_CMD_ID 2
`define MSCT_CMD_CONT 3
`define MSCT_MODE_WB 0
`define MSCT_MODE_RP 1
`define MSCT_MODE_RB 2
// ---------------------------------------------
// Reset and suggested values
// ---------------------------------------------
`define MSCT_FAST_RST 32'h0000_0000
`define MSCT_SLOW_RST 32'h300F_0C00
`define MSCT_FAST_REC 32'h0101_0020
`define MSCT_SLOW_REC 32'h1100_0023
`define MSCT_CLK_NS 40
`endif

// ---- logic/msct_pkg.sv ----
`default_nettype none
package msct_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECOV,
        ST_ADDR,
        ST_GAP,
        ST_STROBE,
        ST_HOLD
    } msct_state_t;
endpackage : msct_pkg
`default_nettype wire

// ---- tb/msct_ctrl_bench.sv ----
`include "msct_map.svh"
`default_nettype none
module msct_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [31:0] fast;
        logic [31:0] slow;
        logic [31:0] mode;
        logic [31:0] cmd;
        int rec, lead, st, cs, adr;
    } msct_row_t;
    localparam logic [15:0] ADR = 16'h1234;
    localparam logic [15:0] DAT = 16'hA5C3;
    localparam logic [31:0] F0 = 32'h0, S0 = 32'h300F0C00;
    localparam logic [31:0] FR = 32'h01010020, SR = 32'h11000023;
    localparam logic [31:0] FH = 32'h05000000, FG = 32'h00020000;
    localparam logic [31:0] S2 = 32'h00000002, SF = 32'hF0000002;
    localparam logic [31:0] SW = 32'h00050020, SP = 32'h00000401;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, q;
    logic PREADY, PSLVERR, MEM_CLK, MEM_ADV_N, MEM_OE_N, MEM_WE_N;
    logic MEM_AD_OE, e;
    logic [1:0] MEM_CS_N;
    logic [15:0] MEM_AD_O, MEM_AD_I, pm_addr, pm_wdat;
    int n_fail = 0, n_compared = 0, i;
    int m_rec, m_lead, m_st, m_cs, m_adr, m_adv, m_bad;
    msct_row_t rows [20] = '{
        '{F0, S0, 0, 1, 0, 1, 15, 16, 1},
        '{F0, S0, 0, 0, 0, 1, 12, 13, 1},
        '{F0, S0, 0, 1, 3, 1, 15, 16, 1},
        '{FR, SR, 0, 2, 0, 2, 3, 5, 2},
        '{FR, SR, 0, 0, 1, 2, 3, 5, 2},
        '{FR, SR, 0, 0, 0, 2, 3, 5, 2},
        '{FR, SR, 0, 1, 1, 1, 2, 4, 2},
        '{FH, S2, 0, 0, 0, 5, 2, 7, 1},
        '{FH, S2, 0, 4, 0, 1, 2, 3, 1},
        '{FG, S2, 0, 0, 0, 3, 2, 5, 1},
        '{F0, SF, 0, 3, 15, 1, 1, 2, 1},
        '{F0, S2, 0, 0, 0, 1, 2, 3, 1},
        '{F0, S2, 0, 1, 0, 1, 1, 2, 1},
        '{F0, SW, 1, 1, 0, 1, 7, 8, 1},
        '{F0, SW, 1, 9, 0, 1, 2, 3, 1},
        '{F0, SW, 0, 9, 0, 1, 7, 8, 1},
        '{F0, SP, 2, 0, 0, 1, 5, 6, 1},
        '{F0, SP, 2, 8, 0, 1, 1, 2, 1},
        '{F0, SP, 4, 8, 0, 1, 1, 2, 1},
        '{F0, SP, 0, 8, 0, 1, 5, 6, 1}
    };
    always #20 SYS_CLK = ~SYS_CLK;
    msct_ctrl msct_ctrl_inst (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_CLK(MEM_CLK),
        .MEM_CS_N(MEM_CS_N), .MEM_ADV_N(MEM_ADV_N), .MEM_OE_N(MEM_OE_N),
        .MEM_WE_N(MEM_WE_N), .MEM_AD_O(MEM_AD_O), .MEM_AD_OE(MEM_AD_OE),
        .MEM_AD_I(MEM_AD_I)
    );
    msct_periph_model #(.DLY(2)) msct_periph_model_inst (
        .clk(SYS_CLK), .cs_n(MEM_CS_N), .adv_n(MEM_ADV_N), .oe_n(MEM_OE_N),
        .we_n(MEM_WE_N), .ad_o(MEM_AD_O), .ad_oe(MEM_AD_OE),
        .ad_i(MEM_AD_I), .addr_q(pm_addr), .wdat_q(pm_wdat)
    );
    // ----------------------------------
    // Shared tasks
    // ----------------------------------
    task end_sim;
        if (n_fail == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    task hang;
        n_fail++;
        $display("BAD %0t timeout", $time);
        end_sim();
    endtask : hang
    task cmp(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, g, x);
        end
    endtask : cmp
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] rq, output logic re);
        int k;
        logic r;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        r = 1'b0;
        for (k = 0; k < 20 && !r; k++) begin
            @(posedge SYS_CLK);
            r = (PREADY === 1'b1);
            rq = PRDATA;
            re = PSLVERR;
        end
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (!r) begin
            hang();
        end
    endtask : apb
    // Counts each segment of one access, from the cycle after the command
    task access(input logic [3:0] c);
        int k;
        logic sl;
        logic seen;
        m_rec = 0;
        m_lead = 0;
        m_st = 0;
        m_cs = 0;
        m_adr = 0;
        m_adv = 0;
        m_bad = 0;
        seen = 1'b0;
        for (k = 0; k < 100; k++) begin
            @(negedge SYS_CLK);
            sl = c[0] ? (MEM_WE_N === 1'b0) : (MEM_OE_N === 1'b0);
            if (MEM_CS_N === 2'b11) begin
                if (seen) break;
                m_rec++;
            end else begin
                seen = 1'b1;
                m_cs++;
                if (sl) m_st++;
                else if (m_st == 0) m_lead++;
                if (MEM_AD_OE === 1'b1 && MEM_AD_O === ADR) m_adr++;
                if (MEM_ADV_N === 1'b0) m_adv++;
                if (MEM_CS_N !== (c[1] ? 2'b01 : 2'b10)) m_bad++;
            end
            if ((c[0] ? MEM_OE_N : MEM_WE_N) !== 1'b1) m_bad++;
            if (MEM_CLK !== 1'b0) m_bad++;
            if (MEM_OE_N === 1'b0 && MEM_AD_OE !== 1'b0) m_bad++;
        end
        if (k == 100) begin
            hang();
        end
    endtask : access
    task chk_rst;
        @(negedge SYS_CLK);
        cmp({MEM_CLK, MEM_ADV_N, MEM_OE_N, MEM_WE_N, MEM_AD_OE, MEM_CS_N},
            32'h3B);
        apb(1'b0, `MSCT_OFS_FAST, 32'h0, q, e);
        cmp(q, F0);
        apb(1'b0, `MSCT_OFS_SLOW, 32'h0, q, e);
        cmp(q, S0);
    endtask : chk_rst
    // ----------------------------------
    // Main sequence
    // ----------------------------------
    initial begin
        repeat (10) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        chk_rst();
        cmp(`MSCT_FAST_REC, FR);
        cmp(`MSCT_SLOW_REC, SR);
        apb(1'b1, `MSCT_OFS_ADDR, {16'h0, ADR}, q, e);
        apb(1'b1, `MSCT_OFS_DATA, {16'h0, DAT}, q, e);
        for (i = 0; i < 20; i++) begin
            apb(1'b1, `MSCT_OFS_FAST, rows[i].fast, q, e);
            apb(1'b1, `MSCT_OFS_SLOW, rows[i].slow, q, e);
            apb(1'b1, `MSCT_OFS_MODE, rows[i].mode, q, e);
            apb(1'b1, `MSCT_OFS_CMD, rows[i].cmd, q, e);
            access(rows[i].cmd[3:0]);
            cmp(m_rec, rows[i].rec);
            cmp(m_lead, rows[i].lead);
            cmp(m_st, rows[i].st);
            cmp(m_cs, rows[i].cs);
            cmp(m_adr, rows[i].adr);
            cmp(m_adv, 1);
            cmp(m_bad, 0);
            cmp(pm_addr, ADR);
            if (rows[i].cmd[0]) cmp(pm_wdat, DAT);
        end
        // Long read returns the peripheral word through the filter
        apb(1'b1, `MSCT_OFS_SLOW, S0, q, e);
        apb(1'b1, `MSCT_OFS_CMD, 32'h0, q, e);
        access(4'h0);
        apb(1'b0, `MSCT_OFS_DATA, 32'h0, q, e);
        cmp(q, {16'h0, ~ADR});
        apb(1'b0, `MSCT_OFS_STAT, 32'h0, q, e);
        cmp(q, 32'h2);
        // A command while busy must not start a second access
        apb(1'b1, `MSCT_OFS_CMD, 32'h1, q, e);
        apb(1'b0, `MSCT_OFS_STAT, 32'h0, q, e);
        cmp(q[0], 1'b1);
        apb(1'b1, `MSCT_OFS_CMD, 32'h2, q, e);
        m_bad = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge SYS_CLK);
            if (MEM_CS_N === 2'b01) m_bad++;
        end
        cmp(m_bad, 0);
        cmp(pm_wdat, DAT);
        apb(1'b0, 12'hFFC, 32'h0, q, e);
        cmp(e, 1'b1);
        cmp(q, 32'h0);
        apb(1'b1, 12'h01C, 32'hFFFFFFFF, q, e);
        cmp(e, 1'b1);
        // Reset in mid-access, with both timing words moved off their
        // reset values so that the reset really has to restore them
        apb(1'b1, `MSCT_OFS_CMD, 32'h0, q, e);
        apb(1'b1, `MSCT_OFS_FAST, FR, q, e);
        apb(1'b1, `MSCT_OFS_SLOW, SR, q, e);
        repeat (3) @(posedge SYS_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        chk_rst();
        end_sim();
    end
endmodule : msct_ctrl_bench
`default_nettype wire

// ---- tb/msct_periph_model.sv ----
`default_nettype none
module msct_periph_model #(
    parameter int DLY = 2
) (
    input wire logic clk,
    input wire logic [1:0] cs_n,
    input wire logic adv_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] ad_o,
    input wire logic ad_oe,
    output logic [15:0] ad_i,
    output logic [15:0] addr_q,
    output logic [15:0] wdat_q
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last_q = 16'h0000;
    int oe_cnt_q = 0;
    // Released lines float: show the inverse of the last level, so a
    // design that samples them too early sees a changing pattern
    assign ad_i = ad_oe ? ad_o : (oe_cnt_q >= DLY) ? ~addr_q : ~last_q;
    always @(posedge clk) begin
        last_q <= ad_i;
        oe_cnt_q <= (oe_n || cs_n == 2'b11) ? 0 : oe_cnt_q + 1;
        if (!adv_n && cs_n != 2'b11) begin
            addr_q <= ad_i;
        end
        if (!we_n && cs_n != 2'b11) begin
            wdat_q <= ad_i;
        end
    end
endmodule : msct_periph_model
`default_nettype wire
